// file: host_writer_model.sv
module host_writer_model
   import serial_tx_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic cascade,
   input wire logic slow,
   output logic hostWriteClock,
   output logic chipEnableN,
   output logic txWriteEnable,
   output charIn_t txIn
);
   timeunit 1ns;
   timeprecision 1ps;
   charIn_t pending[$];
   charIn_t held;
   logic prevEn;
   logic [1:0] div;
   always @(posedge clock) begin
      if (reset) begin
         hostWriteClock <= 1'b0;
         div <= 2'h0;
      end else if (div == 2'h0) begin
         div <= slow ? 2'h2 : 2'h0;
         hostWriteClock <= ~hostWriteClock;
      end else begin
         div <= div - 2'h1;
      end
   end
   // bus changes as the host clock falls, well away from its sampled rise
   always @(posedge clock) begin
      if (reset) begin
         chipEnableN <= 1'b1;
         txWriteEnable <= 1'b1;
         txIn <= '0;
         prevEn <= 1'b0;
      end else if (div == 2'h0 && hostWriteClock) begin
         prevEn <= pending.size() != 0;
         chipEnableN <= pending.size() == 0;
         txWriteEnable <= (pending.size() != 0) ~^ cascade;
         // idle data lines toggle so a stale value never looks valid
         if (cascade) begin
            txIn <= prevEn ? held : ~txIn;
         end else begin
            txIn <= pending.size() != 0 ? pending[0] : ~txIn;
         end
         if (pending.size() != 0) begin
            held <= pending.pop_front();
         end
      end
   end
endmodule

// file: serial_tx_fifo_encoder.sv
module serial_tx_fifo_encoder #(
   parameter int DEPTH = serial_tx_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic hostWriteClock,
   input wire logic chipEnableN,
   input wire logic txWriteEnable,
   input wire serial_tx_pkg::charIn_t txIn,
   output logic txBufferEmptyFlag,
   output logic txBufferHalfFlag,
   output logic txBufferFullFlag,
   output logic serialOutPrimary,
   output logic serialOutSecondary,
   output logic loopbackStream
);
   import serial_tx_pkg::*;

   logic [7:0] ctrl;
   logic bufferBypassN, encoderBypassN, charWidthSelect, speedBandSelect;
   logic refclkRangeSelect, loopbackSelect, cascadeModeSelect, txSelftestEnableN;
   assign bufferBypassN = ctrl[CTRL_BUFFER_BYPASS_N];
   assign encoderBypassN = ctrl[CTRL_ENCODER_BYPASS_N];
   assign charWidthSelect = ctrl[CTRL_WIDTH];
   assign speedBandSelect = ctrl[CTRL_SPEED];
   assign refclkRangeSelect = ctrl[CTRL_RANGE];
   assign loopbackSelect = ctrl[CTRL_LOOPBACK];
   assign cascadeModeSelect = ctrl[CTRL_CASCADE];
   assign txSelftestEnableN = ctrl[CTRL_SELFTEST_N];

   // 4B/5B symbol for a data nibble
   function automatic logic [4:0] sym5(input logic [3:0] n);
      case (n)
         4'h0: sym5 = 5'h1e;
         4'h1: sym5 = 5'h09;
         4'h2: sym5 = 5'h14;
         4'h3: sym5 = 5'h15;
         4'h4: sym5 = 5'h0a;
         4'h5: sym5 = 5'h0b;
         4'h6: sym5 = 5'h0e;
         4'h7: sym5 = 5'h0f;
         4'h8: sym5 = 5'h12;
         4'h9: sym5 = 5'h13;
         4'ha: sym5 = 5'h16;
         4'hb: sym5 = 5'h17;
         4'hc: sym5 = 5'h1a;
         4'hd: sym5 = 5'h1b;
         4'he: sym5 = 5'h1c;
         default: sym5 = 5'h1d;
      endcase
   endfunction

   // command pairs of J K T R S Q H I symbols, Q and H being violations
   function automatic logic [9:0] cmd10(input logic [3:0] c);
      case (c)
         4'h0: cmd10 = 10'h311;
         4'h1: cmd10 = 10'h3ff;
         4'h2: cmd10 = 10'h1ad;
         4'h3: cmd10 = 10'h1b9;
         4'h4: cmd10 = 10'h3e4;
         4'h5: cmd10 = 10'h1a7;
         4'h6: cmd10 = 10'h327;
         4'h7: cmd10 = 10'h339;
         4'h8: cmd10 = 10'h084;
         4'h9: cmd10 = 10'h09f;
         4'ha: cmd10 = 10'h080;
         4'hb: cmd10 = 10'h0e7;
         4'hc: cmd10 = 10'h0f9;
         4'hd: cmd10 = 10'h004;
         4'he: cmd10 = 10'h01f;
         default: cmd10 = 10'h000;
      endcase
   endfunction

   // 5B/6B: data gets an odd-parity bit on top so no symbol is all zeros
   function automatic logic [5:0] sym6(input logic [4:0] d);
      sym6 = {~^d, d};
   endfunction

   function automatic logic [11:0] cmd12(input logic [1:0] c);
      case (c)
         2'h0: cmd12 = 12'h65a;
         2'h1: cmd12 = 12'h3cf;
         2'h2: cmd12 = 12'h000;
         default: cmd12 = 12'hfff;
      endcase
   endfunction

   // the code tables list the first bit sent as MSB; the shifter sends LSB first
   function automatic logic [11:0] reverse(input logic [11:0] v, input logic long);
      logic [11:0] r;
      r = '0;
      for (int i = 0; i < 12; i++) begin
         r[i] = long ? v[11 - i] : (i < 10 ? v[9 - i] : 1'b0);
      end
      return r;
   endfunction

   function automatic logic [11:0] encodeChar(input charIn_t c, input logic wide8,
         input logic bypassN);
      logic [11:0] v;
      v = '0;
      if (!bypassN) begin
         // pre-encoded characters pass untouched; 12-bit order ends 10 then 11
         v = wide8 ? {2'b00, c.data} : {c.cmd, c.data};
      end else if (wide8) begin
         if (c.sc) begin
            // data bit 8 is the top command bit, data bit 9 the next one
            v = reverse({2'b00, cmd10({c.data[8], c.data[9], c.cmd})}, 1'b0);
         end else begin
            v = reverse({2'b00, sym5(c.data[7:4]), sym5(c.data[3:0])}, 1'b0);
         end
      end else begin
         if (c.sc) begin
            v = reverse(cmd12(c.cmd), 1'b1);
         end else begin
            v = reverse({sym6(c.data[8:4]), sym6({c.data[9], c.data[3:0]})}, 1'b1);
         end
      end
      return v;
   endfunction

   // bit clock ratio to the reference clock, in tenths
   function automatic logic [7:0] ratio(input logic spd, input logic rng, input logic wide8);
      logic [7:0] r;
      if (spd == rng) begin
         r = 8'h32;
      end else if (spd) begin
         r = 8'h64;
      end else begin
         r = 8'h19;
      end
      return wide8 ? r : 8'((r * 6) / 5);
   endfunction

   // bus slave
   logic busHit;
   logic [31:0] statusWord;
   txState_t state;
   logic [COUNT_BITS-1:0] count;
   logic emptyLvl, halfLvl, fullLvl;
   assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clock) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= busHit;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl <= CTRL_RESET;
      end else if (busHit && wb_we_i && wb_adr_i == CTRL_ADDR && wb_sel_i[0]) begin
         ctrl <= wb_dat_i[7:0];
      end
   end

   always_comb begin
      statusWord = '0;
      statusWord[STAT_COUNT +: COUNT_BITS] = count;
      statusWord[STAT_EMPTY] = emptyLvl;
      statusWord[STAT_HALF] = halfLvl;
      statusWord[STAT_FULL] = fullLvl;
      statusWord[STAT_MULT +: 8] = ratio(speedBandSelect, refclkRangeSelect,
            charWidthSelect);
      statusWord[STAT_STATE +: 2] = state;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wb_dat_o <= '0;
      end else if (busHit && !wb_we_i) begin
         case (wb_adr_i)
            CTRL_ADDR: wb_dat_o <= {24'h000000, ctrl};
            STATUS_ADDR: wb_dat_o <= statusWord;
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // write side
   // host clock is a plain synchronous input; its rising edge marks a host cycle
   logic hostClockPrev, hostEdge, writeSlot;
   logic enAsserted, selected, writeCond, delayedCond, writeNow;
   logic [ENTRY_BITS-1:0] mem [DEPTH];
   logic [7:0] wrPtr, rdPtr;
   logic readNow;
   charIn_t inputReg;
   logic inputValid;

   always_ff @(posedge clock) begin
      if (reset) begin
         hostClockPrev <= 1'b0;
      end else begin
         hostClockPrev <= hostWriteClock;
      end
   end
   assign hostEdge = hostWriteClock && !hostClockPrev;
   // buffer off: every reference clock is a write slot
   assign writeSlot = bufferBypassN ? hostEdge : 1'b1;

   assign enAsserted = cascadeModeSelect ? txWriteEnable : !txWriteEnable;
   assign writeCond = enAsserted && (selected || !chipEnableN);

   always_ff @(posedge clock) begin
      if (reset) begin
         selected <= 1'b0;
         delayedCond <= 1'b0;
      end else if (writeSlot) begin
         selected <= writeCond;
         delayedCond <= writeCond;
      end
   end

   // cascade timing writes the data that arrives one cycle after the enable
   // the flag lags one host slot, so the live count guards the last entry
   assign writeNow = writeSlot && (cascadeModeSelect ? delayedCond : writeCond)
         && !(bufferBypassN && count >= COUNT_BITS'(DEPTH));

   always_ff @(posedge clock) begin
      if (reset) begin
         wrPtr <= '0;
      end else if (writeNow && bufferBypassN) begin
         wrPtr <= wrPtr + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (writeNow && bufferBypassN) begin
         mem[wrPtr] <= {1'b0, txIn};
      end
   end

   // direct path when the buffer is off; a fresh capture beats consumption
   always_ff @(posedge clock) begin
      if (reset) begin
         inputReg <= '0;
         inputValid <= 1'b0;
      end else if (writeNow && !bufferBypassN) begin
         inputReg <= txIn;
         inputValid <= 1'b1;
      end else if (readNow && !bufferBypassN) begin
         inputValid <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset || !bufferBypassN) begin
         count <= '0;
      end else begin
         count <= count + COUNT_BITS'(writeNow) - COUNT_BITS'(readNow);
      end
   end

   // with the buffer on, flags only move on host edges, so a stalled host clock freezes them
   always_ff @(posedge clock) begin
      if (reset) begin
         emptyLvl <= 1'b1;
         halfLvl <= 1'b0;
         fullLvl <= 1'b0;
      end else if (writeSlot) begin
         emptyLvl <= count == '0;
         halfLvl <= count >= COUNT_BITS'(HALF_LEVEL);
         fullLvl <= count >= COUNT_BITS'(DEPTH);
      end
   end

   assign txBufferEmptyFlag = cascadeModeSelect ? emptyLvl : !emptyLvl;
   assign txBufferFullFlag = cascadeModeSelect ? fullLvl : !fullLvl;
   assign txBufferHalfFlag = halfLvl;

   // control, holding register, shifter
   logic [3:0] bitCount, charLen;
   logic charTick;
   charIn_t holding, fifoOut;
   logic [LFSR_BITS-1:0] lfsr;
   logic [11:0] shifter;
   logic nrzi, haveData;

   assign charLen = charWidthSelect ? SHORT_CHAR : LONG_CHAR;
   // load instant depends on this free counter and the width select alone
   assign charTick = bitCount == charLen - 4'h1;

   always_ff @(posedge clock) begin
      if (reset || charTick) begin
         bitCount <= '0;
      end else begin
         bitCount <= bitCount + 4'h1;
      end
   end

   assign fifoOut = charIn_t'(mem[rdPtr][ENTRY_BITS-2:0]);
   assign haveData = bufferBypassN ? count != '0 : inputValid;
   // self-test stops reads at once, so no entry is dropped while the lfsr runs
   assign readNow = charTick && txSelftestEnableN && state != SELFTEST && haveData;

   always_ff @(posedge clock) begin
      if (reset) begin
         rdPtr <= '0;
      end else if (readNow && bufferBypassN) begin
         rdPtr <= rdPtr + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= FILL;
      end else if (charTick) begin
         case (state)
            FILL, SEND: begin
               if (!txSelftestEnableN) begin
                  state <= SELFTEST;
               end else begin
                  state <= haveData ? SEND : FILL;
               end
            end
            SELFTEST: state <= txSelftestEnableN ? FILL : SELFTEST;
            default: state <= FILL;
         endcase
      end
   end

   // x^9 + x^5 + 1 gives the 511-step cycle
   always_ff @(posedge clock) begin
      if (reset || txSelftestEnableN) begin
         lfsr <= LFSR_SEED;
      end else if (charTick) begin
         lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         holding <= '0;
      end else if (charTick) begin
         if (!txSelftestEnableN) begin
            holding <= '{sc: lfsr[8], cmd: lfsr[1:0], data: {lfsr[1:0], lfsr[7:0]}};
         end else if (readNow) begin
            holding <= bufferBypassN ? fifoOut : inputReg;
         end else begin
            holding <= '{sc: 1'b1, cmd: 2'b00, data: 10'h000};
         end
      end
   end

   // the holding value is valid one character after it loads
   logic holdingIsSync;
   always_ff @(posedge clock) begin
      if (reset) begin
         holdingIsSync <= 1'b1;
      end else if (charTick) begin
         holdingIsSync <= txSelftestEnableN && !readNow;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         shifter <= '0;
      end else if (charTick) begin
         if (holdingIsSync) begin
            shifter <= charWidthSelect ? {2'b00, SYNC_SHORT} : SYNC_LONG;
         end else begin
            shifter <= encodeChar(holding, charWidthSelect, encoderBypassN);
         end
      end else begin
         shifter <= {1'b0, shifter[11:1]};
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         nrzi <= 1'b0;
      end else if (shifter[0]) begin
         nrzi <= !nrzi;
      end
   end

   assign serialOutPrimary = nrzi;
   // in loopback the secondary line idles so the far end sees no traffic
   assign serialOutSecondary = loopbackSelect ? 1'b0 : nrzi;
   assign loopbackStream = loopbackSelect ? nrzi : 1'b0;
endmodule

// file: serial_tx_fifo_encoder_assertions.sv
module serial_tx_fifo_encoder_assertions
   import serial_tx_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic hostWriteClock,
   input wire logic txBufferEmptyFlag,
   input wire logic txBufferHalfFlag,
   input wire logic txBufferFullFlag,
   input wire logic serialOutPrimary,
   input wire logic serialOutSecondary,
   input wire logic loopbackStream
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cascade;
   logic hostPrev;
   wire hostRise = hostWriteClock & ~hostPrev;
   // empty and full pins flip polarity with the cascade bit, so judge the asserted level
   wire emptyOn = txBufferEmptyFlag ~^ cascade;
   wire fullOn = txBufferFullFlag ~^ cascade;
   wire ctrlWrite = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == CTRL_ADDR;
   always_ff @(posedge clock) begin
      hostPrev <= hostWriteClock;
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         cascade <= 1'b0;
      end else if (ctrlWrite && wb_sel_i[0]) begin
         cascade <= wb_dat_i[CTRL_CASCADE];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_half_host_edge: assert property ($changed(txBufferHalfFlag) |-> $past(hostRise))
      else $error("half flag moved off a host edge");
   a_full_half: assert property (fullOn && $stable(cascade) |-> txBufferHalfFlag)
      else $error("full without half");
   a_half_not_empty: assert property (txBufferHalfFlag |-> !emptyOn)
      else $error("half and empty together");
   a_reset_flags: assert property ($fell(reset) |-> emptyOn && !fullOn && !txBufferHalfFlag)
      else $error("flags wrong after reset");
   a_route_excl: assert property (!(serialOutSecondary && loopbackStream))
      else $error("secondary and loopback both driven");
   a_route_copy: assert property (serialOutSecondary || loopbackStream |-> serialOutPrimary)
      else $error("routed stream differs from primary");
   cover property (fullOn);
   cover property (txBufferHalfFlag && cascade);
   cover property (loopbackStream);
endmodule

bind serial_tx_fifo_encoder serial_tx_fifo_encoder_assertions chk (.*);

// file: serial_tx_pkg.sv
package serial_tx_pkg;
   localparam int FIFO_DEPTH = 256;
   localparam int ENTRY_BITS = 14;
   localparam int HALF_LEVEL = 128;
   localparam int COUNT_BITS = 9;
   localparam int LFSR_BITS = 9;
   localparam logic [8:0] LFSR_SEED = 9'h1ff;

   // register byte addresses on the bus
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;

   // control register field positions
   localparam int CTRL_BUFFER_BYPASS_N = 0;
   localparam int CTRL_ENCODER_BYPASS_N = 1;
   localparam int CTRL_WIDTH = 2;
   localparam int CTRL_SPEED = 3;
   localparam int CTRL_RANGE = 4;
   localparam int CTRL_LOOPBACK = 5;
   localparam int CTRL_CASCADE = 6;
   localparam int CTRL_SELFTEST_N = 7;
   localparam logic [7:0] CTRL_RESET = 8'h87;

   // status register field positions
   localparam int STAT_COUNT = 0;
   localparam int STAT_EMPTY = 9;
   localparam int STAT_HALF = 10;
   localparam int STAT_FULL = 11;
   localparam int STAT_MULT = 12;
   localparam int STAT_STATE = 20;

   // character lengths in bits
   localparam logic [3:0] SHORT_CHAR = 4'ha;
   localparam logic [3:0] LONG_CHAR = 4'hc;

   // sync characters, already in transmit order
   localparam logic [9:0] SYNC_SHORT = 10'h311;
   localparam logic [11:0] SYNC_LONG = 12'h9a6;

   typedef struct packed {
      logic sc;
      logic [1:0] cmd;
      logic [9:0] data;
   } charIn_t;

   typedef enum logic [1:0] {
      FILL,
      SEND,
      SELFTEST
   } txState_t;
endpackage

// file: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import serial_tx_pkg::*;
   logic clock, reset, wbCyc, wbStb, wbWe, ack, cascade, slow;
   logic hostClk, ceN, wrEn, emptyF, halfF, fullF, serial_out_primary, serial_out_secondary, outL;
   logic [3:0] wbAdr, wbSel;
   logic [31:0] wbDat, datO, q;
   charIn_t txIn;
   logic [9:0] win;
   logic [9:0] expq[$];
   logic lastLine, aligned, armed, hunting;
   int phase, huntLeft, numErrors, totalChecks, seedDummy, n;
   serial_tx_fifo_encoder dut (.clock(clock), .reset(reset), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDat), .wb_dat_o(datO), .wb_ack_o(ack), .hostWriteClock(hostClk),
      .chipEnableN(ceN), .txWriteEnable(wrEn), .txIn(txIn), .txBufferEmptyFlag(emptyF),
      .txBufferHalfFlag(halfF), .txBufferFullFlag(fullF), .serialOutPrimary(serial_out_primary),
      .serialOutSecondary(serial_out_secondary), .loopbackStream(outL));
   host_writer_model host (.clock(clock), .reset(reset), .cascade(cascade), .slow(slow),
      .hostWriteClock(hostClk), .chipEnableN(ceN), .txWriteEnable(wrEn), .txIn(txIn));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [3:0] adr, input logic we, input logic [31:0] d);
      int k;
      wbAdr <= adr;
      wbSel <= 4'hf;
      wbWe <= we;
      wbDat <= d;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = datO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (k >= 50) begin
         numErrors++;
         tally_and_finish();
      end else begin
         @(posedge clock);
      end
   endtask
   task automatic send(input int cnt, input logic record);
      charIn_t c;
      for (int i = 0; i < cnt; i++) begin
         c = '{sc: 1'b0, cmd: 2'($urandom), data: 10'($urandom)};
         if (c.data == SYNC_SHORT) c.data = 10'h0;
         host.pending.push_back(c);
         if (record) expq.push_back(c.data);
      end
   endtask
   task automatic send_coded(input logic [9:0] d, input logic [9:0] e);
      charIn_t c;
      c = '{sc: 1'b0, cmd: 2'h0, data: d};
      host.pending.push_back(c);
      expq.push_back(e);
   endtask
   // every routed copy must follow the primary line, bit for bit
   task automatic check_route(input logic loop);
      repeat (10) begin
         @(posedge clock);
         check_val({serial_out_secondary, outL}, loop ? {1'b0, serial_out_primary} : {serial_out_primary, 1'b0});
      end
   endtask
   task automatic drain(input logic all);
      n = 0;
      while ((host.pending.size() != 0 || (all && expq.size() != 0)) && n < 9000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 9000) begin
         numErrors++;
         tally_and_finish();
      end else begin
         // flags settle at the next host slots
         repeat (12) @(posedge clock);
      end
   endtask
   // line watcher: undo NRZI, frame on the sync character, keep a fixed phase after
   always @(posedge clock) begin
      win = {serial_out_primary ^ lastLine, win[9:1]};
      lastLine = serial_out_primary;
      if (reset) begin
         aligned = 1'b0;
         lastLine = 1'b0;
      end else if (!aligned) begin
         aligned = win === SYNC_SHORT;
         phase = 0;
      end else if (++phase == 10) begin
         phase = 0;
         if (armed && win !== SYNC_SHORT) begin
            // leftover self-test characters may still be in the pipe
            if (hunting && expq.size() != 0 && win !== expq[0] && huntLeft-- > 0);
            else begin
               hunting = 1'b0;
               check_val(32'(win), expq.size() != 0 ? 32'(expq.pop_front()) : 'x);
            end
         end
      end
   end
   initial begin
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDat, cascade, slow, armed, hunting} = '0;
      reset = 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      seedDummy = $urandom(32'he6471515);
      @(posedge clock);
      check_val({emptyF, fullF, halfF}, 3'b010);
      bus(CTRL_ADDR, 1'b0, '0);
      check_val(q, 32'(CTRL_RESET));
      bus(STATUS_ADDR, 1'b0, '0);
      check_val(q & 32'hfffff, 32'h32200);
      bus(4'hc, 1'b0, '0);
      check_val(q, '0);
      $display("test reset done");
      for (n = 0; n < 200 && !aligned; n++) @(posedge clock);
      check_val(aligned, 1'b1);
      bus(CTRL_ADDR, 1'b1, 32'h85);
      armed <= 1'b1;
      send(24, 1'b1);
      drain(1'b1);
      check_route(1'b0);
      slow <= 1'b1;
      send(8, 1'b1);
      drain(1'b1);
      slow <= 1'b0;
      $display("test stream done");
      armed <= 1'b0;
      bus(CTRL_ADDR, 1'b1, 32'h05);
      send(127, 1'b1);
      drain(1'b0);
      check_val(halfF, 1'b0);
      send(1, 1'b1);
      drain(1'b0);
      check_val(halfF, 1'b1);
      bus(STATUS_ADDR, 1'b0, '0);
      check_val(q & 32'hfff, 32'h480);
      send(128, 1'b1);
      drain(1'b0);
      check_val(fullF, 1'b0);
      send(1, 1'b0);
      drain(1'b0);
      bus(STATUS_ADDR, 1'b0, '0);
      check_val(q & 32'hfff, 32'hd00);
      huntLeft = 4;
      hunting <= 1'b1;
      armed <= 1'b1;
      bus(CTRL_ADDR, 1'b1, 32'h85);
      drain(1'b1);
      $display("test fill done");
      cascade <= 1'b1;
      bus(CTRL_ADDR, 1'b1, 32'hc5);
      check_val({emptyF, fullF}, 2'b10);
      send(16, 1'b1);
      drain(1'b1);
      check_val({emptyF, fullF}, 2'b10);
      $display("test cascade done");
      cascade <= 1'b0;
      bus(CTRL_ADDR, 1'b1, 32'ha5);
      send(8, 1'b1);
      drain(1'b1);
      check_route(1'b1);
      $display("test loopback done");
      bus(CTRL_ADDR, 1'b1, 32'h87);
      send_coded(10'h000, 10'h1ef);
      send_coded(10'h05a, 10'h1ba);
      send_coded(10'h30f, 10'h2ef);
      drain(1'b1);
      $display("test encode done");
      tally_and_finish();
   end
endmodule
